// ===== core/spi_byte_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants of the byte-wide serial port
// Assumes: single core clock, 20 MHz
// Notes:   constants only
//////////////////////////////////////////////////////////////////////////////
package spi_byte_pkg;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned EDGES_PER_BYTE = 2 * BYTE_BITS;
  localparam int unsigned SYNC_STAGES    = 3;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [3:0]  EDGE_LAST      = 4'hF;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_FULL       = 4'h8;
  // Rate select code n gives a half period of 2**n core clocks
  localparam logic [1:0]  RATE_DIV2      = 2'h0;
  localparam logic [1:0]  RATE_DIV16     = 2'h3;
endpackage

// ===== core/pin_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to clock
// Notes:   level only moves when stages two and three agree
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clock,   // core clock
  input  wire logic reset_n, // async reset
  input  wire logic pin,     // raw pin level
  output logic      level    // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1    <= RESET_LEVEL;
      s2    <= RESET_LEVEL;
      s3    <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/rate_divider.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: half-period tick generator for the master serial clock
// Assumes: rate select stable during a byte
// Notes:   tick is a registered one-cycle pulse
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module rate_divider (
  input  wire logic       clock,    // core clock
  input  wire logic       reset_n,  // async reset
  input  wire logic       run,      // count while high
  input  wire logic [1:0] rate_sel, // divider code
  output logic            tick      // half-period pulse
);
  import spi_byte_pkg::*;

  logic [2:0] count;
  wire  [3:0] half_len  = 4'h1 << rate_sel;
  wire  [2:0] count_end = 3'(half_len - 4'h1);
  wire        wrap      = run && (count == count_end);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 3'h0;
      tick  <= 1'b0;
    end else begin
      count <= (!run || wrap) ? 3'h0 : 3'(count + 3'h1);
      tick  <= wrap;
    end
  end
endmodule
`default_nettype wire

// ===== core/spi_master_slave_byte_port.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: byte-wide serial port, master or slave, with done and collision flags
// Assumes: control bits are static while a byte is in flight
// Notes:   pins split into in, out and active-low output enable
// Behaviour
// - Master drives serial clock and emits eight periods per data write.
// - Master clock rate picked by two rate-select bits dividing core clock.
// - Master ignores slave select; software selects slaves by a port pin.
// - Master shifts one bit out and samples one bit in each period.
// - After eighth clock set done flag and request interrupt if enabled.
// - Master copies received byte into data register when shifting ends.
// - Slave: data write loads the byte to be shifted out.
// - Slave drives one bit out and captures one bit in per period.
// - Slave copies received byte only after the whole byte completes.
// - Slave end: eighth clock with phase one, select rising with phase zero.
// - Done flag clears on software clear or on data register read.
// - Data write during a transfer sets collision flag; software clears it.
// - Phase set: data changes on leading edge; clear: on trailing edge.
// - Eight bits per byte, most significant bit first on both lines.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_byte_port (
  input  wire logic       clock,                // core clock, 20 MHz
  input  wire logic       reset_n,              // async reset
  input  wire logic       port_enable_bit,      // port on
  input  wire logic       master_select_bit,    // 1 master, 0 slave
  input  wire logic       clk_polarity,         // idle level of clock
  input  wire logic       clk_phase,            // 1 leading edge drives
  input  wire logic       bit_rate_sel_hi,      // rate select high
  input  wire logic       bit_rate_sel_lo,      // rate select low
  input  wire logic       irq_enable,           // interrupt enable
  input  wire logic       data_wr,              // data register write pulse
  input  wire logic [7:0] data_wr_value,        // byte written
  input  wire logic       data_rd,              // data register read pulse
  input  wire logic       done_clear,           // software clears done
  input  wire logic       collision_clear,      // software clears collision
  output logic      [7:0] shift_data_reg,       // received byte
  output logic            xfer_done_flag,       // byte finished
  output logic            write_collision_flag, // write while busy
  output logic            irq_req,              // interrupt request
  output logic            select_level,         // synced select pin level
  input  wire logic       serial_clk_line_in,   // clock pin in
  output logic            serial_clk_line_out,  // clock pin out
  output logic            serial_clk_line_oe_n, // clock pin drive, low on
  input  wire logic       mosi_in,              // master-out pin in
  output logic            mosi_out,             // master-out pin out
  output logic            mosi_oe_n,            // master-out drive, low on
  input  wire logic       miso_in,              // master-in pin in
  output logic            miso_out,             // master-in pin out
  output logic            miso_oe_n,            // master-in drive, low on
  input  wire logic       slave_select_n        // slave select pin
);
  import spi_byte_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [7:0] tx_sr;
  logic [7:0] rx_sr;
  logic       tx_bit;
  logic       m_run;
  logic [3:0] m_edge;
  logic [3:0] s_cnt;
  logic       sclk_q;
  logic       sclk_f;
  logic       sclk_p;
  logic       ss_f;
  logic       ss_p;
  logic       mosi_f;
  logic       tick;
  logic       m_sample_q;
  logic       m_done_q;

  wire       master    = port_enable_bit && master_select_bit;
  wire       slave     = port_enable_bit && !master_select_bit;
  wire [1:0] rate_sel  = {bit_rate_sel_hi, bit_rate_sel_lo};
  wire       busy      = m_run || (s_cnt != 4'h0);
  wire       wr_ok     = data_wr && port_enable_bit && !busy;
  wire       collide   = data_wr && port_enable_bit && busy;
  wire       m_start   = wr_ok && master;
  wire       m_tick    = m_run && tick;
  wire       m_lead    = m_tick && !m_edge[0];
  wire       m_trail   = m_tick && m_edge[0];
  wire       m_done    = m_tick && (m_edge == EDGE_LAST);
  // Slave select only matters in slave mode
  wire       s_active  = slave && !ss_f;
  wire       s_chg     = s_active && (sclk_f != sclk_p);
  wire       s_lead    = s_chg && (sclk_f != clk_polarity);
  wire       s_trail   = s_chg && (sclk_f == clk_polarity);
  wire       ss_rise   = slave && ss_f && !ss_p;
  // Phase picks which edge samples and which drives
  wire       m_sample  = clk_phase ? m_trail : m_lead;
  wire       m_drive   = clk_phase ? m_lead : (m_trail && !m_done);
  wire       s_sample  = clk_phase ? s_trail : s_lead;
  wire       s_drive   = clk_phase ? s_lead : s_trail;
  // Master pins lag the sequencer by one flop; sampling follows the pin
  wire       sample    = m_sample_q || s_sample;
  wire       drive     = m_drive || s_drive;
  wire       rx_bit    = master ? miso_in : mosi_f;
  wire [7:0] rx_next   = {rx_sr[6:0], rx_bit};
  wire       s_done_p1 = s_sample && clk_phase && (s_cnt == BIT_LAST);
  wire       s_done_p0 = ss_rise && !clk_phase && (s_cnt == BIT_FULL);
  wire       s_done    = s_done_p1 || s_done_p0;
  wire       done      = m_done_q || s_done;
  wire       next_done = done || (xfer_done_flag && !(done_clear || data_rd));
  wire       next_coll = collide || (write_collision_flag && !collision_clear);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and rate divider
  pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (serial_clk_line_in),
    .level   (sclk_f)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_ss (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (slave_select_n),
    .level   (ss_f)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) u_sync_mosi (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (mosi_in),
    .level   (mosi_f)
  );

  rate_divider u_rate (
    .clock    (clock),
    .reset_n  (reset_n),
    .run      (m_run),
    .rate_sel (rate_sel),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      m_run  <= 1'b0;
      m_edge <= 4'h0;
      sclk_q <= 1'b0;
      m_sample_q <= 1'b0;
      m_done_q   <= 1'b0;
    end else begin
      m_sample_q <= m_sample;
      m_done_q   <= m_done;
      if (m_start) begin
        m_run  <= 1'b1;
        m_edge <= 4'h0;
      end else if (m_tick) begin
        m_run  <= !m_done;
        m_edge <= 4'(m_edge + 4'h1);
      end
      if (m_tick) begin
        sclk_q <= !sclk_q;
      end else if (!m_run) begin
        sclk_q <= clk_polarity;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave edge history and bit count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_p <= 1'b0;
      ss_p   <= 1'b1;
      s_cnt  <= 4'h0;
    end else begin
      sclk_p <= sclk_f;
      ss_p   <= ss_f;
      if (!slave || s_done || ss_rise) begin
        s_cnt <= 4'h0;
      end else if (s_sample) begin
        s_cnt <= 4'(s_cnt + 4'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared shift path
  // Phase zero must present the first bit before any edge, so load drives it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_sr  <= DATA_RESET;
      tx_bit <= 1'b0;
      rx_sr  <= DATA_RESET;
    end else begin
      if (wr_ok && clk_phase) begin
        tx_sr <= data_wr_value;
      end else if (wr_ok) begin
        tx_sr  <= {data_wr_value[6:0], 1'b0};
        tx_bit <= data_wr_value[7];
      end else if (drive) begin
        tx_sr  <= {tx_sr[6:0], 1'b0};
        tx_bit <= tx_sr[7];
      end
      if (sample) begin
        rx_sr <= rx_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, data register and pin outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_data_reg       <= DATA_RESET;
      xfer_done_flag       <= 1'b0;
      write_collision_flag <= 1'b0;
      irq_req              <= 1'b0;
      select_level         <= 1'b1;
      serial_clk_line_out  <= 1'b0;
      serial_clk_line_oe_n <= 1'b1;
      mosi_out             <= 1'b0;
      mosi_oe_n            <= 1'b1;
      miso_out             <= 1'b0;
      miso_oe_n            <= 1'b1;
    end else begin
      if (m_done_q) begin
        shift_data_reg <= m_sample_q ? rx_next : rx_sr;
      end else if (s_done) begin
        shift_data_reg <= s_sample ? rx_next : rx_sr;
      end
      xfer_done_flag       <= next_done;
      write_collision_flag <= next_coll;
      irq_req              <= next_done && irq_enable;
      select_level         <= ss_f;
      serial_clk_line_out  <= sclk_q;
      serial_clk_line_oe_n <= !master;
      mosi_out             <= tx_bit;
      mosi_oe_n            <= !master;
      miso_out             <= tx_bit;
      miso_oe_n            <= !s_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [3:0] gap;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 4'h0;
    end else begin
      gap <= (m_start || tick) ? 4'h0 : 4'(gap + 4'h1);
    end
  end
  wire [3:0] half_m1 = 4'((4'h1 << rate_sel) - 4'h1);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_started;
    m_start ##1 m_run;
  endsequence
  sequence s_finished;
    ##[1:300] m_done;
  endsequence

  property p_burst;
    s_started |-> s_finished;
  endproperty
  a_burst: assert property (p_burst) else $error("master burst did not end");

  property p_edges;
    m_done |=> !m_run && sclk_q == clk_polarity;
  endproperty
  a_edges: assert property (p_edges) else $error("burst left clock off idle");

  property p_rate;
    m_tick && $past(m_run) && m_edge != 4'h0 |-> gap == half_m1;
  endproperty
  a_rate: assert property (p_rate) else $error("half period wrong");

  property p_no_ss_master;
    master |-> s_cnt == 4'h0 && !s_done;
  endproperty
  a_no_ss_master: assert property (p_no_ss_master) else $error("select used in master");

  property p_latch;
    m_done_q && !m_sample_q |=> shift_data_reg == $past(rx_sr);
  endproperty
  a_latch: assert property (p_latch) else $error("received byte not latched");

  property p_done_irq;
    done |=> xfer_done_flag && (irq_req || !$past(irq_enable));
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done flag or irq missing");

  property p_read_clear;
    data_rd && !done |=> !xfer_done_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear done");

  property p_collide;
    data_wr && port_enable_bit && busy |=>
      write_collision_flag && ($stable(tx_sr) || $past(drive));
  endproperty
  a_collide: assert property (p_collide) else $error("collision not flagged");

  property p_idle;
    !m_run && $past(!m_run) && !$past(tick) |-> sclk_q == $past(clk_polarity);
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle level wrong");

  property p_slave_end;
    s_done && !clk_phase |-> ss_f && !ss_p;
  endproperty
  a_slave_end: assert property (p_slave_end) else $error("phase zero end without select");
endmodule
`default_nettype wire

// ===== verification/spi_far_end.sv
// Purpose: far-side serial device, slave or master by mode
// Assumes: mode bits static while a byte is in flight
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input  wire logic sclk,     // clock wire
  input  wire logic mosi,     // master-out wire
  input  wire logic miso,     // master-in wire
  input  wire logic as_slave, // far side acts as slave
  input  wire logic cpol,     // clock idle level
  input  wire logic cpha,     // clock phase
  output logic      sclk_o,   // clock when master
  output logic      mosi_o,   // data when master
  output logic      miso_o,   // data when slave
  output logic      sel_n_o   // select when master
);
  logic [7:0] sh;
  logic [7:0] rx_q;
  logic       lead;
  int         lead_cnt = 0;
  int         outs     = 8;
  int         per_ns   = 0;
  realtime    t_lead;
  initial begin
    sclk_o  = 1'b0;
    mosi_o  = 1'b0;
    miso_o  = 1'b0;
    sel_n_o = 1'b1;
  end
  task automatic load(input logic [7:0] v);
    lead_cnt = 0;
    outs     = 0;
    sh       = v;
    if (!cpha) begin
      miso_o = sh[7];
      sh     = sh << 1;
      outs   = 1;
    end
  endtask
  // Slave side: one edge shifts out, the other samples
  always @(sclk) begin
    if (as_slave) begin
      lead = (sclk !== cpol);
      if (lead) begin
        if (lead_cnt > 0) per_ns = int'($realtime - t_lead);
        t_lead   = $realtime;
        lead_cnt = lead_cnt + 1;
      end
      if (lead != cpha) begin
        rx_q = {rx_q[6:0], mosi};
      end else if (outs < 8) begin
        miso_o = sh[7];
        sh     = sh << 1;
        outs   = outs + 1;
      end else begin
        // Hold time over: stale bit must not pass
        miso_o = ~miso_o;
      end
    end
  end
  ////////////////////////////////////////
  // Master side: select stays low at return, so the caller sees the byte end
  task automatic exchange(input logic [7:0] v, input int half_ns);
    sclk_o = cpol;
    #(half_ns);
    sel_n_o = 1'b0;
    if (!cpha) mosi_o = v[7];
    #(half_ns);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = ~cpol;
      if (cpha) mosi_o = v[i];
      else rx_q = {rx_q[6:0], miso};
      #(half_ns);
      sclk_o = cpol;
      if (cpha) rx_q = {rx_q[6:0], miso};
      else if (i > 0) mosi_o = v[i-1];
      else mosi_o = ~mosi_o;
      #(half_ns);
    end
  endtask
  task automatic release_sel();
    sel_n_o = 1'b1;
    mosi_o  = ~mosi_o;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_spi_master_slave_byte_port.sv
// Purpose: self-checking bench of the byte-wide serial port
// Assumes: far-side model on the pins, software strobes as plain ports
// Notes:   inputs move 2 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_byte_port;
  import spi_byte_pkg::*;
  logic       clock, reset_n, port_enable_bit, master_select_bit, clk_polarity;
  logic       clk_phase, bit_rate_sel_hi, bit_rate_sel_lo, irq_enable, data_wr;
  logic       data_rd, done_clear, collision_clear, slave_select_n;
  logic [7:0] data_wr_value, shift_data_reg, old;
  logic       xfer_done_flag, write_collision_flag, irq_req, select_level;
  logic       serial_clk_line_out, serial_clk_line_oe_n, mosi_out, mosi_oe_n;
  logic       miso_out, miso_oe_n, far_sclk, far_mosi, far_miso;
  wire logic  sclk_w, mosi_w, miso_w;
  int         err_total, comparisons, cycles;
  assign sclk_w = !serial_clk_line_oe_n ? serial_clk_line_out : far_sclk;
  assign mosi_w = !mosi_oe_n ? mosi_out : far_mosi;
  assign miso_w = !miso_oe_n ? miso_out : far_miso;
  spi_master_slave_byte_port dut_u (
    .clock, .reset_n, .port_enable_bit, .master_select_bit, .clk_polarity,
    .clk_phase, .bit_rate_sel_hi, .bit_rate_sel_lo, .irq_enable, .data_wr,
    .data_wr_value, .data_rd, .done_clear, .collision_clear, .shift_data_reg,
    .xfer_done_flag, .write_collision_flag, .irq_req, .select_level,
    .serial_clk_line_in(sclk_w), .serial_clk_line_out, .serial_clk_line_oe_n,
    .mosi_in(mosi_w), .mosi_out, .mosi_oe_n, .miso_in(miso_w), .miso_out,
    .miso_oe_n, .slave_select_n);
  spi_far_end far_u (.sclk(sclk_w), .mosi(mosi_w), .miso(miso_w),
    .as_slave(master_select_bit), .cpol(clk_polarity), .cpha(clk_phase),
    .sclk_o(far_sclk), .mosi_o(far_mosi), .miso_o(far_miso),
    .sel_n_o(slave_select_n));
  ////////////////////////////////////////
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic sw_write(input logic [7:0] v);
    data_wr       = 1'b1;
    data_wr_value = v;
    cyc(1);
    data_wr = 1'b0;
  endtask
  task automatic sw_clear(input logic [1:0] sel);
    {data_rd, done_clear} = sel;
    cyc(1);
    {data_rd, done_clear} = 2'b00;
  endtask
  task automatic wait_done(input int lim);
    while (xfer_done_flag !== 1'b1 && lim > 0) begin
      cyc(1);
      lim--;
    end
  endtask
  task automatic master_xfer(input logic [1:0] rate, md, input logic [7:0] tx, fv);
    master_select_bit = 1'b1;
    {bit_rate_sel_hi, bit_rate_sel_lo} = rate;
    {clk_polarity, clk_phase} = md;
    irq_enable = md[0];
    // Idle level settles before the far side arms its edge counter
    cyc(4);
    far_u.load(fv);
    chk(sclk_w, clk_polarity);
    sw_write(tx);
    wait_done(300);
    chk(xfer_done_flag, 1'b1);
    chk(irq_req, md[0]);
    chk(shift_data_reg, fv);
    chk(far_u.rx_q, tx);
    chk(far_u.lead_cnt, BYTE_BITS);
    chk(far_u.per_ns / 50, 2 << rate);
    sw_clear({md[1], ~md[1]});
    chk(xfer_done_flag, 1'b0);
    chk(sclk_w, clk_polarity);
  endtask
  task automatic slave_xfer(input logic [1:0] md, input logic [7:0] tx, mv);
    master_select_bit = 1'b0;
    {clk_polarity, clk_phase} = md;
    cyc(4);
    old = shift_data_reg;
    chk(miso_oe_n, 1'b1);
    sw_write(tx);
    far_u.exchange(mv, 500);
    cyc(1);
    chk(select_level, 1'b0);
    chk(xfer_done_flag, md[0]);
    chk(shift_data_reg, md[0] ? mv : old);
    far_u.release_sel();
    wait_done(30);
    chk(shift_data_reg, mv);
    chk(far_u.rx_q, tx);
    sw_clear(2'b01);
    chk(xfer_done_flag, 1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Whole run is near 2100 cycles; ceiling leaves ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 15000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {reset_n, master_select_bit, clk_polarity, clk_phase, irq_enable} = 5'h00;
    {bit_rate_sel_hi, bit_rate_sel_lo, data_wr, data_rd} = 4'h0;
    {done_clear, collision_clear} = 2'b00;
    port_enable_bit = 1'b1;
    data_wr_value   = 8'h00;
    cyc(5);
    chk(serial_clk_line_oe_n, 1'b1);
    chk(select_level, 1'b1);
    reset_n = 1'b1;
    cyc(1);
    chk(shift_data_reg, DATA_RESET);
    chk(xfer_done_flag, 1'b0);
    for (int m = 0; m < 16; m++) begin
      master_xfer(m[3:2], m[1:0], {m[3:0], ~m[3:0]}, 8'ha5 ^ {2{m[3:0]}});
    end
    far_u.load(8'h3c);
    sw_write(8'hc6);
    cyc(20);
    sw_write(8'h11);
    cyc(1);
    chk(write_collision_flag, 1'b1);
    wait_done(300);
    chk(far_u.rx_q, 8'hc6);
    chk(shift_data_reg, 8'h3c);
    collision_clear = 1'b1;
    cyc(1);
    collision_clear = 1'b0;
    chk(write_collision_flag, 1'b0);
    sw_clear(2'b10);
    port_enable_bit = 1'b0;
    cyc(4);
    far_u.load(8'h00);
    sw_write(8'h77);
    cyc(60);
    chk(xfer_done_flag, 1'b0);
    chk(far_u.lead_cnt, 0);
    port_enable_bit = 1'b1;
    for (int m = 0; m < 4; m++) begin
      slave_xfer(m[1:0], 8'h96 ^ m[7:0], 8'h2b + m[7:0]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
